// file: rtl/cmc_consts.svh
// register offsets, field positions, reset values and code constants of the mode control block
`ifndef CMC_CONSTS_SVH
`define CMC_CONSTS_SVH
`define CMC_MODE_OFS 12'h000
`define CMC_STAT_OFS 12'h004
`define CMC_CAL_OFS 12'h008
`define CMC_CAL_STRIDE 12'h008
`define CMC_ADDR_BITS 12
`define CMC_POL_BIT 12
`define CMC_PEN_BIT 11
`define CMC_PB1_BIT 10
`define CMC_PB0_BIT 9
`define CMC_WID_BIT 8
`define CMC_REF_BIT 7
`define CMC_RSV_BIT 6
`define CMC_SPAN_HI 5
`define CMC_SPAN_LO 4
`define CMC_CKD_BIT 3
`define CMC_OSC_BIT 2
`define CMC_PAIR_HI 1
`define CMC_PAIR_LO 0
`define CMC_MODE_RST 16'h0030
`define CMC_MODE_WMASK 16'h1FBF
`define CMC_OFS_RST 24'h800000
`define CMC_GAIN_RST 24'h500000
`define CMC_DAC_NONE 8'h20
`define CMC_LEN_SHORT 5'h10
`define CMC_LEN_LONG 5'h18
`endif

// file: rtl/cmc_pkg.sv
// types shared by the converter mode control block
package cmc_pkg;
   typedef enum logic [1:0] {SPAN_10MV = 2'h0, SPAN_20MV = 2'h1, SPAN_40MV = 2'h2,
      SPAN_80MV = 2'h3} cmc_span_t;
   typedef struct packed {
      logic unipolar;
      logic port_output_enable;
      logic [1:0] port_output_bits;
      logic result_width_select;
      logic reference_scale_select;
      logic rsv;
      cmc_span_t input_span_select;
      logic clock_output_disable;
      logic open_sensor_current_enable;
      logic [1:0] input_pair_select;
   } cmc_mode_t;
   typedef struct packed {
      logic pos_first_pos;   // positive mux leg: first_pos_input
      logic pos_first_neg;   // positive mux leg: first_neg_input
      logic pos_second_pos;  // positive mux leg: second_pos_input_port1
      logic neg_first_neg;   // negative mux leg: first_neg_input
      logic neg_second_neg;  // negative mux leg: second_neg_input_port0
   } cmc_mux_t;
   typedef enum logic [2:0] {CAL_IDLE = 3'b001, CAL_OFFSET = 3'b010,
      CAL_GAIN = 3'b100} cmc_cal_st_t;
endpackage

// file: rtl/cmc_mode_ctrl.sv
// mode control field register and decode for a bridge converter, AHB-Lite slave
`include "cmc_consts.svh"

// Overview of operation
// - polarity bit 0: bipolar offset-binary coding of results
// - polarity bit 1: unipolar straight binary coding of results
// - port enable 1 turns second input pins into driven digital outputs
// - enabled port pins drive written bit levels until rewritten or disabled
// - width bit selects 16 or 24 bit result reads
// - span field selects 10, 20, 40 or 80 mV, reset 80 mV
// - clock output disable holds clock output pin low
// - with clock output off, conversion runs only on external clock
// - open-sensor bit enables source on positive, sink on negative input
// - pair select picks inputs and calibration pair per table
// - three offset and gain calibration register pairs, indexed by pair
// - span applies after offset DAC subtraction, 0x20 means none
// - calibration updates selected pair then returns to idle
module cmc_mode_ctrl
   import cmc_pkg::*;
(
   input wire logic hclk,                // system clock
   input wire logic hresetn,             // async reset, low
   input wire logic hsel,                // slave select
   input wire logic [31:0] haddr,        // byte address
   input wire logic [1:0] htrans,        // transfer type
   input wire logic hwrite,              // write strobe
   input wire logic [2:0] hsize,         // transfer size
   input wire logic hready,              // bus ready in
   input wire logic [31:0] hwdata,       // write data
   output logic [31:0] hrdata,           // read data
   output logic hreadyout,               // slave ready
   output logic hresp,                   // always okay
   input wire logic [23:0] raw_result,   // signed modulator result
   input wire logic raw_valid,           // result strobe
   output logic [23:0] result_word,      // coded, width-trimmed result
   output logic [4:0] result_len,        // serial bits per data read
   output logic [1:0] port_pin_o,        // port pin levels [1]=pos2 [0]=neg2
   output logic [1:0] port_pin_oe,       // port pin drivers
   output logic clock_out,               // master clock output pin level
   input wire logic ext_clock_src,       // strap: 1 external clock
   output logic conv_clock_run,          // conversion clock runs
   output logic ref_scale_high,          // reference scale to analog
   output cmc_span_t span_sel,           // span to analog front end
   output logic [7:0] span_offset_dac,   // offset dac to subtract first
   output logic src_pos_en,              // source current on positive
   output logic sink_neg_en,             // sink current on negative
   output cmc_mux_t mux_sel,             // input mux legs
   output logic [1:0] cal_pair_idx,      // calibration pair in use
   input wire logic cal_start,           // calibration begins
   input wire logic cal_is_gain,         // 1 gain, 0 offset
   input wire logic cal_done,            // calibration value ready
   input wire logic [23:0] cal_value,    // measured coefficient
   output logic cal_busy,                // calibration running
   output logic cal_to_idle,             // pulse: return to idle mode
   output logic [23:0] cal_offset,       // offset coefficient in use
   output logic [23:0] cal_gain          // gain coefficient in use
);

   cmc_mode_t mode_r;
   logic [15:0] mode_bits;
   logic [7:0] dac_r;
   logic [23:0] ofs_r [0:2];
   logic [23:0] gain_r [0:2];
   logic ph_wr_r;
   logic ph_rd_r;
   logic [`CMC_ADDR_BITS-1:0] ph_addr_r;
   logic ext_s1_r;
   logic ext_s2_r;
   logic ext_sel_r;
   logic [1:0] cal_pair_r;
   cmc_cal_st_t cal_st_r;
   logic [23:0] coded;
   logic addr_take;

   // pair index from pair select; 00 and 10 share pair 0
   function automatic logic [1:0] pair_of(input logic [1:0] sel);
      unique case (sel)
         2'h0: pair_of = 2'h0;
         2'h1: pair_of = 2'h1;
         2'h2: pair_of = 2'h0;
         default: pair_of = 2'h2;
      endcase
   endfunction

   // which calibration slot a byte address hits, 3 when none
   function automatic logic [1:0] slot_of(input logic [`CMC_ADDR_BITS-1:0] a);
      logic [`CMC_ADDR_BITS-1:0] d;
      d = a - `CMC_CAL_OFS;
      slot_of = 2'h3;
      if (a >= `CMC_CAL_OFS && d < 3 * `CMC_CAL_STRIDE)
         slot_of = d[4:3];
   endfunction

   // unpack a written word into fields; the reserved bit is never stored
   function automatic cmc_mode_t mode_of(input logic [15:0] w);
      cmc_mode_t m;
      m = '0;
      m.unipolar = w[`CMC_POL_BIT];
      m.port_output_enable = w[`CMC_PEN_BIT];
      m.port_output_bits = w[`CMC_PB1_BIT:`CMC_PB0_BIT];
      m.result_width_select = w[`CMC_WID_BIT];
      m.reference_scale_select = w[`CMC_REF_BIT];
      m.rsv = 1'b0;
      m.input_span_select = cmc_span_t'(w[`CMC_SPAN_HI:`CMC_SPAN_LO]);
      m.clock_output_disable = w[`CMC_CKD_BIT];
      m.open_sensor_current_enable = w[`CMC_OSC_BIT];
      m.input_pair_select = w[`CMC_PAIR_HI:`CMC_PAIR_LO];
      mode_of = m;
   endfunction

   // pack fields into the read word; reserved and top bits read zero
   function automatic logic [15:0] word_of(input cmc_mode_t m);
      logic [15:0] w;
      w = 16'h0;
      w[`CMC_POL_BIT] = m.unipolar;
      w[`CMC_PEN_BIT] = m.port_output_enable;
      w[`CMC_PB1_BIT] = m.port_output_bits[1];
      w[`CMC_PB0_BIT] = m.port_output_bits[0];
      w[`CMC_WID_BIT] = m.result_width_select;
      w[`CMC_REF_BIT] = m.reference_scale_select;
      w[`CMC_RSV_BIT] = 1'b0;
      w[`CMC_SPAN_HI:`CMC_SPAN_LO] = m.input_span_select;
      w[`CMC_CKD_BIT] = m.clock_output_disable;
      w[`CMC_OSC_BIT] = m.open_sensor_current_enable;
      w[`CMC_PAIR_HI:`CMC_PAIR_LO] = m.input_pair_select;
      word_of = w;
   endfunction

   assign mode_bits = word_of(mode_r);
   assign addr_take = hsel & hready & htrans[1];

   // address phase latch; all transfers complete with no wait state
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ph_wr_r <= 1'b0;
         ph_rd_r <= 1'b0;
         ph_addr_r <= '0;
      end
      else if (hready)
      begin
         ph_wr_r <= addr_take & hwrite;
         ph_rd_r <= addr_take & ~hwrite;
         ph_addr_r <= haddr[`CMC_ADDR_BITS-1:0];
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // mode register; reserved bit forced to zero since writing it is a host fault
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mode_r <= cmc_mode_t'(13'(`CMC_MODE_RST));
      else if (ph_wr_r && ph_addr_r == `CMC_MODE_OFS)
         mode_r <= mode_of(hwdata[15:0] & `CMC_MODE_WMASK);
   end

   // offset dac value, low byte of the status word when written
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         dac_r <= `CMC_DAC_NONE;
      else if (ph_wr_r && ph_addr_r == `CMC_STAT_OFS)
         dac_r <= hwdata[7:0];
   end

   // external clock strap: two-flop synchroniser, then a held copy for status and run logic
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
      end
      else
      begin
         ext_s1_r <= ext_clock_src;
         ext_s2_r <= ext_s1_r;
      end
   end

   always_ff @(posedge hclk)
      ext_sel_r <= ext_s2_r;

   // calibration sequencer: the pair is frozen at start so a mid-run
   // rewrite of pair select cannot misdirect the result
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cal_st_r <= CAL_IDLE;
         cal_pair_r <= 2'h0;
      end
      else
      begin
         unique case (cal_st_r)
            CAL_IDLE:
               if (cal_start)
               begin
                  cal_pair_r <= pair_of(mode_r.input_pair_select);
                  cal_st_r <= cal_is_gain ? CAL_GAIN : CAL_OFFSET;
               end
            CAL_OFFSET, CAL_GAIN:
               if (cal_done)
                  cal_st_r <= CAL_IDLE;
            default:
               cal_st_r <= CAL_IDLE;
         endcase
      end
   end

   assign cal_busy = (cal_st_r != CAL_IDLE);
   assign cal_to_idle = cal_busy & cal_done;

   // three coefficient pairs; calibration result wins over a bus write
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_pair
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               ofs_r[gi] <= `CMC_OFS_RST;
               gain_r[gi] <= `CMC_GAIN_RST;
            end
            else if (cal_done && cal_busy && cal_pair_r == 2'(gi))
            begin
               if (cal_st_r == CAL_OFFSET)
                  ofs_r[gi] <= cal_value;
               else
                  gain_r[gi] <= cal_value;
            end
            else if (ph_wr_r && slot_of(ph_addr_r) == 2'(gi))
            begin
               if (ph_addr_r[2])
                  gain_r[gi] <= hwdata[23:0];
               else
                  ofs_r[gi] <= hwdata[23:0];
            end
         end
      end
   endgenerate

   assign cal_pair_idx = pair_of(mode_r.input_pair_select);
   assign cal_offset = ofs_r[cal_pair_idx];
   assign cal_gain = gain_r[cal_pair_idx];

   // read data driven combinationally in the data phase from the latched address
   always_comb
   begin
      logic [1:0] s;
      s = slot_of(ph_addr_r);
      hrdata = 32'h0;
      if (ph_rd_r)
      begin
         if (ph_addr_r == `CMC_MODE_OFS)
            hrdata = {16'h0, mode_bits};
         else if (ph_addr_r == `CMC_STAT_OFS)
            hrdata = {20'h0, ext_sel_r, cal_busy, cal_pair_idx, dac_r};
         else if (s != 2'h3)
            hrdata = {8'h0, ph_addr_r[2] ? gain_r[s] : ofs_r[s]};
      end
   end

   // output coding: bipolar flips the sign bit to get offset binary,
   // unipolar clamps negatives to zero
   always_comb
   begin
      if (!mode_r.unipolar)
         coded = {~raw_result[23], raw_result[22:0]};
      else if (raw_result[23])
         coded = 24'h0;
      else
         coded = {raw_result[22:0], 1'b0};
   end

   // result word; 16-bit mode keeps the upper bits, low byte zero
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         result_word <= 24'h0;
      else if (raw_valid)
         result_word <= mode_r.result_width_select ? coded :
            {coded[23:8], 8'h0};
   end

   assign result_len = mode_r.result_width_select ? `CMC_LEN_LONG : `CMC_LEN_SHORT;

   // port pins: drivers follow enable, levels follow written bits while enabled, zero otherwise
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         port_pin_o <= 2'h0;
         port_pin_oe <= 2'h0;
      end
      else
      begin
         port_pin_oe <= {2{mode_r.port_output_enable}};
         port_pin_o <= mode_r.port_output_enable ?
            mode_r.port_output_bits : 2'h0;
      end
   end

   // clock output: gated copy of the master clock, low when disabled;
   // clock-pin gating is glitch-prone, a cell library gate would be used
   assign clock_out = hclk & ~mode_r.clock_output_disable;
   assign conv_clock_run = ~mode_r.clock_output_disable | ext_sel_r;

   // analog steering outputs
   assign ref_scale_high = mode_r.reference_scale_select;
   assign span_sel = mode_r.input_span_select;
   assign span_offset_dac = dac_r;
   assign src_pos_en = mode_r.open_sensor_current_enable;
   assign sink_neg_en = mode_r.open_sensor_current_enable;

   // input mux legs per pair select
   always_comb
   begin
      mux_sel = '0;
      unique case (mode_r.input_pair_select)
         2'h0:
         begin
            mux_sel.pos_first_pos = 1'b1;
            mux_sel.neg_first_neg = 1'b1;
         end
         2'h1:
         begin
            mux_sel.pos_second_pos = 1'b1;
            mux_sel.neg_second_neg = 1'b1;
         end
         2'h2:
         begin
            mux_sel.pos_first_neg = 1'b1;
            mux_sel.neg_first_neg = 1'b1;
         end
         2'h3:
         begin
            mux_sel.pos_first_neg = 1'b1;
            mux_sel.neg_second_neg = 1'b1;
         end
      endcase
   end

endmodule // cmc_mode_ctrl

// file: test/cmc_mode_ctrl_chk.sv
// port-level assertion checker for the mode control block
module cmc_mode_ctrl_chk
   import cmc_pkg::*;
(
   input wire logic hclk,                // clock
   input wire logic hresetn,             // reset, low
   input wire logic hreadyout,           // slave ready
   input wire logic hresp,               // response
   input wire logic [4:0] result_len,    // read length
   input wire logic [1:0] port_pin_o,    // port levels
   input wire logic [1:0] port_pin_oe,   // port drivers
   input wire logic src_pos_en,          // source current
   input wire logic sink_neg_en,         // sink current
   input wire cmc_mux_t mux_sel,         // mux legs
   input wire logic [1:0] cal_pair_idx,  // pair index
   input wire logic raw_valid,           // result strobe
   input wire logic [23:0] result_word,  // coded result
   input wire logic cal_start,           // calibration begin
   input wire logic cal_done,            // calibration end
   input wire logic cal_busy,            // calibration running
   input wire logic cal_to_idle          // idle pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   // everything here lives in the one bus clock domain
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus slave stalled or erred");
   a_len_pick: assert property (result_len == 5'h10 || result_len == 5'h18)
      else $error("result length neither 16 nor 24");
   a_port_both: assert property (port_pin_oe[0] == port_pin_oe[1])
      else $error("port drivers disagree");
   a_port_quiet: assert property (!port_pin_oe[0] |-> port_pin_o == 2'h0)
      else $error("port level driven while released");
   a_open_pair: assert property (src_pos_en == sink_neg_en)
      else $error("source and sink currents differ");
   a_pair_one: assert property (mux_sel.pos_second_pos |-> mux_sel.neg_second_neg && cal_pair_idx == 2'h1)
      else $error("second input pair mapped wrongly");
   a_pair_two: assert property (cal_pair_idx == 2'h2 |-> mux_sel.pos_first_neg && mux_sel.neg_second_neg)
      else $error("pair two legs wrong");
   a_result_hold: assert property (!raw_valid |=> $stable(result_word))
      else $error("result changed without a strobe");
   a_cal_begin: assert property (cal_start && !cal_busy |=> cal_busy)
      else $error("calibration did not start");
   a_cal_end: assert property (cal_busy && cal_done |-> cal_to_idle ##1 !cal_busy)
      else $error("calibration did not return to idle");
endmodule // cmc_mode_ctrl_chk

// file: test/cmc_host.sv
// host model: AHB-Lite master reaching the mode control registers
module cmc_host (
   input wire logic hclk,           // clock
   input wire logic hready,         // bus ready
   input wire logic [31:0] hrdata,  // read data
   output logic hsel,               // slave select
   output logic [31:0] haddr,       // address
   output logic [1:0] htrans,       // transfer type
   output logic hwrite,             // write strobe
   output logic [2:0] hsize,        // size
   output logic [31:0] hwdata       // write data
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle bus from time zero
   initial
   begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
   end
   // one single word; each phase held until ready is seen high
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      if (a == 32'h0) d[6] = 1'b0;
      do @(posedge hclk); while (!hready);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (!hready);
      q = hrdata;
      hsel <= 1'b0;
      hwdata <= ~d; // released data shows no stale value
   endtask
endmodule // cmc_host

// file: test/converter_mode_control_fields_tb_top.sv
// testbench for the converter mode control block
module converter_mode_control_fields_tb_top
   import cmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hready, hresp, raw_valid, clock_out, ext_clock_src, conv_clock_run;
   logic ref_scale_high, src_pos_en, sink_neg_en, cal_start, cal_is_gain, cal_done, cal_busy;
   logic cal_to_idle;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, port_pin_o, port_pin_oe, cal_pair_idx;
   logic [2:0] hsize;
   logic [23:0] raw_result, result_word, cal_value, cal_offset, cal_gain;
   logic [4:0] result_len;
   logic [7:0] span_offset_dac;
   cmc_span_t span_sel;
   cmc_mux_t mux_sel;
   logic [4:0] mux_tbl [4] = '{5'h12, 5'h05, 5'h0A, 5'h09};
   logic [1:0] pair_tbl [4] = '{2'h0, 2'h1, 2'h0, 2'h2};
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;

   always #5 hclk = ~hclk;
   // slave ready feeds back as the bus ready
   cmc_mode_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .raw_result(raw_result),
      .raw_valid(raw_valid), .result_word(result_word), .result_len(result_len),
      .port_pin_o(port_pin_o), .port_pin_oe(port_pin_oe), .clock_out(clock_out),
      .ext_clock_src(ext_clock_src), .conv_clock_run(conv_clock_run),
      .ref_scale_high(ref_scale_high), .span_sel(span_sel),
      .span_offset_dac(span_offset_dac), .src_pos_en(src_pos_en),
      .sink_neg_en(sink_neg_en), .mux_sel(mux_sel), .cal_pair_idx(cal_pair_idx),
      .cal_start(cal_start), .cal_is_gain(cal_is_gain), .cal_done(cal_done),
      .cal_value(cal_value), .cal_busy(cal_busy), .cal_to_idle(cal_to_idle),
      .cal_offset(cal_offset), .cal_gain(cal_gain));
   cmc_host host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, rd);
   endtask
   task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
      host.xfer(1'b0, a, 32'h0, rd);
      check(what, rd, exp);
   endtask
   // decoded outputs follow a mode write at most one cycle after it lands
   task automatic settle;
      repeat (2) @(posedge hclk);
      #1;
   endtask
   task automatic conv(input logic [23:0] raw, input logic [23:0] exp);
      @(posedge hclk);
      raw_result <= raw;
      raw_valid <= 1'b1;
      @(posedge hclk);
      raw_valid <= 1'b0;
      @(posedge hclk);
      #1;
      check("result word", result_word, exp);
   endtask
   // one calibration run: start, then done with its value during the one busy cycle
   task automatic cal_run(input logic gain, input logic [23:0] val);
      @(posedge hclk);
      cal_start <= 1'b1;
      cal_is_gain <= gain;
      @(posedge hclk);
      cal_start <= 1'b0;
      cal_done <= 1'b1;
      cal_value <= val;
      #1;
      check("busy", cal_busy, 32'h1);
      @(posedge hclk);
      cal_done <= 1'b0;
      #1;
      check("idle again", cal_busy, 32'h0);
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // hang guard, far above the roughly 140 cycles the tests need
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         results();
      end
   end

   initial
   begin
      {raw_valid, cal_start, cal_is_gain, cal_done, ext_clock_src} = '0;
      raw_result = '0;
      cal_value = '0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rdchk("mode reset", 32'h0, 32'h30);
      rdchk("status reset", 32'h4, 32'h20);
      rdchk("offset pair 2 reset", 32'h18, 32'h800000);
      rdchk("unmapped", 32'hFC, 32'h0);
      check("drivers at reset", port_pin_oe, 32'h0);
      $display("test reset done");
      wr(32'h0, 32'h0C30);
      settle();
      check("drivers on", port_pin_oe, 32'h3);
      check("port levels", port_pin_o, 32'h2);
      wr(32'h0, 32'h0A30);
      settle();
      check("levels rewritten", port_pin_o, 32'h1);
      wr(32'h0, 32'h0230);
      settle();
      check("drivers off", port_pin_oe, 32'h0);
      $display("test ports done");
      for (int p = 0; p < 4; p++)
      begin
         wr(32'h0, 32'h30 | p);
         settle();
         check("mux legs", mux_sel, mux_tbl[p]);
         check("pair index", cal_pair_idx, pair_tbl[p]);
      end
      $display("test pairs done");
      for (int s = 0; s < 4; s++)
      begin
         wr(32'h0, (s << 4) | (s[0] << 8) | (s[1] << 7) | (s[0] << 3) | (s[1] << 2));
         settle();
         check("span", span_sel, s);
         check("length", result_len, s[0] ? 32'h18 : 32'h10);
         check("ref scale", ref_scale_high, s[1]);
         check("open sensor", src_pos_en & sink_neg_en, s[1]);
         check("clock out", clock_out, !s[0]);
         check("conv clock", conv_clock_run, !s[0]);
      end
      @(posedge hclk);
      ext_clock_src <= 1'b1;
      settle();
      settle();
      check("external clock runs", conv_clock_run, 32'h1);
      wr(32'h4, 32'h2A);
      settle();
      check("offset dac", span_offset_dac, 32'h2A);
      rdchk("status after strap", 32'h4, 32'h82A);
      $display("test fields done");
      wr(32'h0, 32'h130);
      settle();
      conv(24'h800000, 24'h000000);
      conv(24'h000000, 24'h800000);
      conv(24'h7FFFFF, 24'hFFFFFF);
      wr(32'h0, 32'h030);
      conv(24'h7FFFFF, 24'hFFFF00);
      wr(32'h0, 32'h1130);
      conv(24'h000000, 24'h000000);
      conv(24'hFFFFFF, 24'h000000);
      conv(24'h7FFFFF, 24'hFFFFFE);
      $display("test coding done");
      wr(32'h0, 32'h31);
      settle();
      cal_run(1'b0, 24'h123456);
      check("offset in use", cal_offset, 32'h123456);
      rdchk("offset pair 1", 32'h10, 32'h123456);
      rdchk("gain pair 1", 32'h14, 32'h500000);
      wr(32'h0, 32'h33);
      settle();
      cal_run(1'b1, 24'h654321);
      check("gain in use", cal_gain, 32'h654321);
      check("pair 2 offset kept", cal_offset, 32'h800000);
      rdchk("gain pair 2", 32'h1C, 32'h654321);
      $display("test calibration done");
      results();
   end
endmodule // converter_mode_control_fields_tb_top

bind cmc_mode_ctrl cmc_mode_ctrl_chk u_chk (.hclk(hclk), .hresetn(hresetn),
   .hreadyout(hreadyout), .hresp(hresp), .result_len(result_len), .port_pin_o(port_pin_o),
   .port_pin_oe(port_pin_oe), .src_pos_en(src_pos_en), .sink_neg_en(sink_neg_en),
   .mux_sel(mux_sel), .cal_pair_idx(cal_pair_idx), .raw_valid(raw_valid),
   .result_word(result_word), .cal_start(cal_start), .cal_done(cal_done),
   .cal_busy(cal_busy), .cal_to_idle(cal_to_idle));
